// [hdl/spi_irq_pkg.sv]
// Shared constants and types for the serial port flag and data block
package spi_irq_pkg;
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned SCK_HALF_NS = 80;
	localparam int unsigned SCK_HALF_CYC = (SCK_HALF_NS * 1000) / CLK_PERIOD_PS;
	localparam logic [4:0] SCK_HALF_LAST = 5'(SCK_HALF_CYC - 1);
	localparam logic [2:0] IRQ_EN_IDX = 3'h2;
	localparam logic [2:0] FLAGS_IDX = 3'h3;
	localparam logic [2:0] DATA_IDX = 3'h4;
	localparam logic [2:0] CONFIG_IDX = 3'h5;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] IRQ_EN_MASK_BUF = 8'hF1;
	localparam logic [7:0] IRQ_EN_MASK_NORM = 8'h01;
	localparam int unsigned RX_DONE_BIT = 7;
	localparam int unsigned TX_DONE_BIT = 6;
	localparam int unsigned TX_EMPTY_BIT = 5;
	localparam int unsigned SEL_TRIG_BIT = 4;
	localparam int unsigned OVF_BIT = 0;
	localparam int unsigned GEN_IE_BIT = 0;
	localparam int unsigned XFER_DONE_BIT = 7;
	localparam int unsigned WCOL_BIT = 6;
	localparam int unsigned CFG_ENABLE_BIT = 0;
	localparam int unsigned CFG_HOST_BIT = 1;
	localparam int unsigned CFG_SEL_DIS_BIT = 2;
	localparam int unsigned CFG_BUF_BIT = 7;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_LOW = 3'b010,
		ST_HIGH = 3'b100
	} host_state_t;

	typedef struct packed
	{
		logic rx_done;
		logic tx_done;
		logic tx_empty;
		logic sel_trig;
		logic ovf;
	} buf_flags_t;

	typedef struct packed
	{
		logic xfer_done;
		logic wcol;
	} norm_flags_t;
endpackage

// [hdl/spi_irq_flags_data_port.sv]
// Serial port interrupt enables, flags and data port behind a Wishbone slave
`timescale 1ns/1ps

module sync2
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic d_i,
	output logic q_o
);
	logic meta_q;

	// First stage feeds only the second
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_q <= 1'b0;
			q_o <= 1'b0;
		end
		else
		begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Function
// - Receive-done enable gates irq in buffered mode
// - Transmit-done enable gates irq in buffered mode
// - Transmit-empty enable gates irq in buffered mode
// - Select-trigger enable gates irq in buffered mode
// - General enable gates transfer-done irq otherwise
// - Transfer-done set after each full byte
// - Host select pin low sets transfer-done
// - Transfer-done clears by vector or read sequence
// - Write during shift sets collision flag
// - Receive-done set per stored byte, write one or emptying read clears
// - Transmit-done set when shifter and buffer empty
// - Transmit-empty set as buffer empties, data write clears
// - Select pulled low in host sets trigger
// - Third byte with full buffer sets overflow
// - Without transmit data, overflow waits transfer start
// - Overflow clears by data read or one
// - Host write starts transfer, client write loads
// - Normal mode data port writes the shifter, reads the single receive register
// - Buffered data port uses transmit/receive buffers
// - Buffer enable gives two receive, one transmit
// - Irq holds while enabled flag stays set
module spi_irq_flags_data_port
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic irq_o,
	input wire logic irq_ack_i,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe_n_o,
	input wire logic mosi_i,
	output logic mosi_o,
	output logic mosi_oe_n_o,
	input wire logic miso_i,
	output logic miso_o,
	output logic miso_oe_n_o,
	input wire logic ss_n_i
);
	import spi_irq_pkg::*;

	logic [7:0] irq_en_q;
	logic enable_q, host_q, sel_dis_q, buf_en_q;
	buf_flags_t bf_q;
	norm_flags_t nf_q;
	logic arm_done_q, arm_wcol_q, ovf_pend_q;
	logic [7:0] tx_sh_q, rx_sh_q, rx_data_q, tx_buf_q, rx_buf_q, rx_hold_q;
	logic tx_valid_q, rx_buf_v_q, rx_hold_v_q, client_loaded_q;
	host_state_t st_q;
	logic [4:0] div_q;
	logic [3:0] bits_q;
	logic sck_s, mosi_s, miso_s, ss_n_s, sck_p_q, ss_n_p_q;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; the link clock is sampled like data
	sync2 u_sync_sck (.clk_i(clk_i), .rst_i(rst_i), .d_i(sck_i), .q_o(sck_s));
	sync2 u_sync_mosi (.clk_i(clk_i), .rst_i(rst_i), .d_i(mosi_i), .q_o(mosi_s));
	sync2 u_sync_miso (.clk_i(clk_i), .rst_i(rst_i), .d_i(miso_i), .q_o(miso_s));
	sync2 u_sync_ss (.clk_i(clk_i), .rst_i(rst_i), .d_i(ss_n_i), .q_o(ss_n_s));

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sck_p_q <= 1'b0;
			ss_n_p_q <= 1'b1;
		end
		else
		begin
			sck_p_q <= sck_s;
			ss_n_p_q <= ss_n_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode; effects happen on the edge that raises ack
	logic wb_hit, wr_lane, rd_acc, mapped;
	logic [2:0] idx;
	logic data_wr, data_rd, data_acc, flags_rd, flags_wr, buffered;
	logic host_mode, client_mode, host_idle, busy, ss_trig;
	logic sck_rise, sck_fall, client_sel, host_start, client_first, xfer_start;
	logic byte_done;
	logic [7:0] rx_byte;
	logic pop_tx, buf_v_after, hold_v_after, ovf_now;

	assign wb_hit = cyc_i & stb_i & ~ack_o;
	assign idx = adr_i[4:2];
	assign mapped = (adr_i[7:5] == 3'h0) && (adr_i[1:0] == 2'h0);
	assign wr_lane = wb_hit & we_i & sel_i[0] & mapped;
	assign rd_acc = wb_hit & ~we_i & mapped;
	assign data_wr = wr_lane && (idx == DATA_IDX);
	assign data_rd = rd_acc && (idx == DATA_IDX);
	assign data_acc = data_wr | data_rd;
	assign flags_rd = rd_acc && (idx == FLAGS_IDX);
	assign flags_wr = wr_lane && (idx == FLAGS_IDX);
	assign buffered = buf_en_q;

	assign host_mode = enable_q & host_q;
	assign client_mode = enable_q & ~host_q;
	assign host_idle = (st_q == ST_IDLE);
	assign busy = host_mode ? ~host_idle : (client_mode & (bits_q != 4'h0));
	// Select pin low while host drops host role
	assign ss_trig = host_mode & ~sel_dis_q & ~ss_n_s;

	assign sck_rise = sck_s & ~sck_p_q;
	assign sck_fall = ~sck_s & sck_p_q;
	assign client_sel = client_mode & ~ss_n_s;
	assign client_first = client_sel & sck_rise & (bits_q == 4'h0);
	// Buffered host starts from the buffer, normal host from the write
	assign host_start = host_mode & host_idle & ~ss_trig
		& (buffered ? tx_valid_q : data_wr);
	assign xfer_start = host_start | client_first;
	// Client pulls the next byte only between bytes
	assign pop_tx = buffered & tx_valid_q
		& (host_start | (client_mode & (bits_q == 4'h0) & ~client_loaded_q));

	// Byte ends on the host's last falling edge or the client's eighth rise
	assign byte_done = host_mode
		? ((st_q == ST_HIGH) && (div_q == SCK_HALF_LAST) && (bits_q == BYTE_BITS))
		: (client_sel & sck_rise & (bits_q == LAST_BIT));
	assign rx_byte = host_mode ? rx_sh_q : {rx_sh_q[6:0], mosi_s};

	assign buf_v_after = (buffered & data_rd) ? rx_hold_v_q : rx_buf_v_q;
	assign hold_v_after = (buffered & data_rd) ? 1'b0 : rx_hold_v_q;
	assign ovf_now = buffered & byte_done & buf_v_after & hold_v_after;

	////////////////////////////////////////////////////////////////////////////////
	// Configuration and enable registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_en_q <= REG_RESET;
			enable_q <= 1'b0;
			host_q <= 1'b0;
			sel_dis_q <= 1'b0;
			buf_en_q <= 1'b0;
		end
		else
		begin
			if (wr_lane && (idx == IRQ_EN_IDX))
				irq_en_q <= dat_i[7:0] & IRQ_EN_MASK_BUF;
			if (wr_lane && (idx == CONFIG_IDX))
			begin
				enable_q <= dat_i[CFG_ENABLE_BIT];
				host_q <= dat_i[CFG_HOST_BIT];
				sel_dis_q <= dat_i[CFG_SEL_DIS_BIT];
				buf_en_q <= dat_i[CFG_BUF_BIT];
			end
			if (ss_trig)
				host_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shift engine; host makes the clock, client follows the sampled one
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_q <= ST_IDLE;
			div_q <= 5'h00;
			bits_q <= 4'h0;
			tx_sh_q <= REG_RESET;
			rx_sh_q <= REG_RESET;
			client_loaded_q <= 1'b0;
		end
		else if (ss_trig || !enable_q)
		begin
			st_q <= ST_IDLE;
			bits_q <= 4'h0;
			client_loaded_q <= 1'b0;
		end
		else if (host_mode)
		begin
			if (host_start)
			begin
				tx_sh_q <= buffered ? tx_buf_q : dat_i[7:0];
				st_q <= ST_LOW;
				div_q <= 5'h00;
				bits_q <= 4'h0;
			end
			else if (!host_idle)
			begin
				div_q <= (div_q == SCK_HALF_LAST) ? 5'h00 : div_q + 5'h01;
				if (div_q == SCK_HALF_LAST)
				begin
					if (st_q == ST_LOW)
					begin
						st_q <= ST_HIGH;
						rx_sh_q <= {rx_sh_q[6:0], miso_s};
						bits_q <= bits_q + 4'h1;
					end
					else if (bits_q == BYTE_BITS)
					begin
						st_q <= ST_IDLE;
						bits_q <= 4'h0;
					end
					else
					begin
						st_q <= ST_LOW;
						tx_sh_q <= {tx_sh_q[6:0], 1'b0};
					end
				end
			end
		end
		else
		begin
			if (ss_n_s)
				bits_q <= 4'h0;
			else if (sck_rise)
			begin
				rx_sh_q <= {rx_sh_q[6:0], mosi_s};
				bits_q <= (bits_q == LAST_BIT) ? 4'h0 : bits_q + 4'h1;
				client_loaded_q <= 1'b0;
			end
			else if (sck_fall && bits_q != 4'h0)
				tx_sh_q <= {tx_sh_q[6:0], 1'b0};
			if (pop_tx)
			begin
				tx_sh_q <= tx_buf_q;
				client_loaded_q <= 1'b1;
			end
			else if (!buffered && data_wr && !busy)
				tx_sh_q <= dat_i[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmit buffer, one stage
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_buf_q <= REG_RESET;
			tx_valid_q <= 1'b0;
		end
		else
		begin
			if (pop_tx)
				tx_valid_q <= 1'b0;
			if (buffered && data_wr)
			begin
				tx_buf_q <= dat_i[7:0];
				tx_valid_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receive path: single register, or two buffered stages
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rx_data_q <= REG_RESET;
			rx_buf_q <= REG_RESET;
			rx_hold_q <= REG_RESET;
			rx_buf_v_q <= 1'b0;
			rx_hold_v_q <= 1'b0;
		end
		else if (!buffered)
		begin
			if (byte_done)
				rx_data_q <= rx_byte;
		end
		else
		begin
			// Reading moves the held byte forward
			if (data_rd)
			begin
				rx_buf_q <= rx_hold_q;
				rx_buf_v_q <= rx_hold_v_q;
				rx_hold_v_q <= 1'b0;
			end
			if (byte_done && !buf_v_after)
			begin
				rx_buf_q <= rx_byte;
				rx_buf_v_q <= 1'b1;
			end
			else if (byte_done && !hold_v_after)
			begin
				rx_hold_q <= rx_byte;
				rx_hold_v_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Normal mode flags; each set is applied after its clear so it wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			nf_q <= '0;
			arm_done_q <= 1'b0;
			arm_wcol_q <= 1'b0;
		end
		else
		begin
			if (flags_rd && !buffered)
			begin
				arm_done_q <= nf_q.xfer_done;
				arm_wcol_q <= nf_q.wcol;
			end
			if (data_acc)
			begin
				arm_done_q <= 1'b0;
				arm_wcol_q <= 1'b0;
				if (arm_done_q)
					nf_q.xfer_done <= 1'b0;
				if (arm_wcol_q)
					nf_q.wcol <= 1'b0;
			end
			if (irq_ack_i)
				nf_q.xfer_done <= 1'b0;
			if (!buffered && (byte_done || ss_trig))
				nf_q.xfer_done <= 1'b1;
			if (!buffered && data_wr && busy)
				nf_q.wcol <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Buffered mode flags; write one clears all but transmit-empty, hardware set wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			bf_q <= '0;
			ovf_pend_q <= 1'b0;
		end
		else
		begin
			if (flags_wr)
			begin
				if (dat_i[RX_DONE_BIT])
					bf_q.rx_done <= 1'b0;
				if (dat_i[TX_DONE_BIT])
					bf_q.tx_done <= 1'b0;
				if (dat_i[SEL_TRIG_BIT])
					bf_q.sel_trig <= 1'b0;
				if (dat_i[OVF_BIT])
					bf_q.ovf <= 1'b0;
			end
			if (buffered && data_rd)
			begin
				bf_q.rx_done <= rx_hold_v_q;
				bf_q.ovf <= 1'b0;
			end
			if (buffered && byte_done && !(buf_v_after && hold_v_after))
				bf_q.rx_done <= 1'b1;
			if (buffered && byte_done && !tx_valid_q)
				bf_q.tx_done <= 1'b1;
			if (buffered && data_wr)
				bf_q.tx_empty <= 1'b0;
			else if (pop_tx)
				bf_q.tx_empty <= 1'b1;
			if (buffered && ss_trig)
				bf_q.sel_trig <= 1'b1;
			// Loss with nothing to send is reported at the next start
			if (ovf_now && !tx_valid_q)
				ovf_pend_q <= 1'b1;
			else if (xfer_start)
				ovf_pend_q <= 1'b0;
			if ((ovf_now && tx_valid_q) || (xfer_start && ovf_pend_q))
				bf_q.ovf <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt request is a level; it holds until software clears the enabled flag or, in normal mode, the vector acknowledge clears it
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else if (buffered)
			irq_o <= (irq_en_q[RX_DONE_BIT] & bf_q.rx_done)
				| (irq_en_q[TX_DONE_BIT] & bf_q.tx_done)
				| (irq_en_q[TX_EMPTY_BIT] & bf_q.tx_empty)
				| (irq_en_q[SEL_TRIG_BIT] & bf_q.sel_trig);
		else
			irq_o <= irq_en_q[GEN_IE_BIT] & nf_q.xfer_done;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus answer; one wait state, unmapped reads return zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end
		else
		begin
			ack_o <= wb_hit;
			dat_o <= 32'h0000_0000;
			if (rd_acc)
			begin
				unique case (idx)
					IRQ_EN_IDX:
						dat_o[7:0] <= irq_en_q
							& (buffered ? IRQ_EN_MASK_BUF : IRQ_EN_MASK_NORM);
					FLAGS_IDX:
						dat_o[7:0] <= buffered
							? {bf_q.rx_done, bf_q.tx_done, bf_q.tx_empty, bf_q.sel_trig, 3'h0, bf_q.ovf}
							: {nf_q.xfer_done, nf_q.wcol, 6'h00};
					DATA_IDX:
						dat_o[7:0] <= buffered ? rx_buf_q : rx_data_q;
					CONFIG_IDX:
						dat_o[7:0] <= {buf_en_q, 4'h0, sel_dis_q, host_q, enable_q};
					default:
						dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin drivers; enables are low while driving
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sck_o <= 1'b0;
			sck_oe_n_o <= 1'b1;
			mosi_o <= 1'b0;
			mosi_oe_n_o <= 1'b1;
			miso_o <= 1'b0;
			miso_oe_n_o <= 1'b1;
		end
		else
		begin
			sck_o <= host_mode & (st_q == ST_HIGH);
			sck_oe_n_o <= ~host_mode;
			mosi_o <= tx_sh_q[7];
			mosi_oe_n_o <= ~host_mode;
			miso_o <= tx_sh_q[7];
			miso_oe_n_o <= ~client_sel;
		end
	end
endmodule

// [dv/spi_far_end.sv]
// Far-end serial device: client while the block hosts, host otherwise
`timescale 1ns/1ps
module spi_far_end
(
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic miso_i,
	output logic sck_o,
	output logic mosi_o,
	output logic miso_o,
	output logic ss_n_o
);
logic [7:0] tx_q;
logic [7:0] rx_q;
logic [7:0] got_q;
initial
begin
	sck_o = 1'h0;
	mosi_o = 1'h0;
	ss_n_o = 1'h1;
	tx_q = 8'h00;
end
assign miso_o = tx_q[7];
////////////////////////////////////////
// Mode 0, MSB first: sample on rise, shift on fall
always @(posedge sck_i)
begin
	rx_q <= {rx_q[6:0], mosi_i};
	got_q <= {got_q[6:0], miso_i};
end
// Spent bits refilled inverted, so a stale line never looks valid
always @(negedge sck_i)
	tx_q <= {tx_q[6:0], ~tx_q[0]};
task load(input logic [7:0] b);
	tx_q = b;
endtask
task sel(input logic v);
	ss_n_o = v;
endtask
// Clock stands low between bytes
task send(input logic [7:0] b);
	ss_n_o = 1'h0;
	for (int i = 7; i >= 0; i--)
	begin
		mosi_o = b[i];
		#80 sck_o = 1'h1;
		#80 sck_o = 1'h0;
	end
	mosi_o = ~mosi_o;
endtask
endmodule

// [dv/spi_port_checker_assertions.sv]
// Port-level assertions for the serial flag and data block
`timescale 1ns/1ps
module spi_port_checker
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic irq_o,
	input wire logic irq_ack_i,
	input wire logic sck_o,
	input wire logic sck_oe_n_o,
	input wire logic mosi_oe_n_o,
	input wire logic miso_oe_n_o,
	input wire logic ss_n_i
);
import spi_irq_pkg::*;
logic wr;
logic [7:0] cfg_q;
logic [7:0] ie_q;
logic prev_q;
logic [7:0] run_q;
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
////////////////////////////////////////
// Shadows only see software writes, not the hardware role drop
always_ff @(posedge clk_i)
begin
	if (rst_i)
	begin
		cfg_q <= 8'h00;
		ie_q <= 8'h00;
	end
	else if (wr && adr_i == 8'h14)
		cfg_q <= dat_i[7:0];
	else if (wr && adr_i == 8'h08)
		ie_q <= dat_i[7:0];
end
always_ff @(posedge clk_i)
begin
	prev_q <= sck_o;
	run_q <= (sck_o != prev_q) ? 8'h00 : run_q + 8'h01;
end
////////////////////////////////////////
property p_start_sck;
	wr && adr_i == 8'h10 && cfg_q[7] == 1'h0 && cfg_q[1:0] == 2'h3 |-> ##[1:40] $rose(sck_o);
endproperty
a_start_sck: assert property (p_start_sck) else $error("host write gave no clock");
property p_half;
	$fell(sck_o) |-> run_q == {3'h0, SCK_HALF_LAST};
endproperty
a_half: assert property (p_half) else $error("clock high half wrong length");
property p_irq_hold;
	irq_o && !irq_ack_i && !$past(irq_ack_i) && !(cyc_i && stb_i) |=> irq_o;
endproperty
a_irq_hold: assert property (p_irq_hold) else $error("irq dropped by itself");
property p_irq_norm;
	(cfg_q[7] == 1'h0 && ie_q[0] == 1'h0) [*2] |-> !irq_o;
endproperty
a_irq_norm: assert property (p_irq_norm) else $error("irq without general enable");
property p_irq_buf;
	(cfg_q[7] && ie_q[7:4] == 4'h0) [*2] |-> !irq_o;
endproperty
a_irq_buf: assert property (p_irq_buf) else $error("irq without buffered enable");
property p_ack_rd;
	cyc_i && stb_i && !we_i && !ack_o && adr_i == 8'h10 |=> ack_o && dat_o[31:8] == 24'h0;
endproperty
a_ack_rd: assert property (p_ack_rd) else $error("data read answer wrong");
property p_client_oe;
	(cfg_q[1] == 1'h0) [*2] |-> sck_oe_n_o && mosi_oe_n_o;
endproperty
a_client_oe: assert property (p_client_oe) else $error("client drives host pins");
property p_miso_oe;
	ss_n_i [*4] |-> miso_oe_n_o;
endproperty
a_miso_oe: assert property (p_miso_oe) else $error("miso driven while deselected");
c_irq: cover property ($rose(irq_o));
c_sck: cover property ($fell(sck_o));
c_miso: cover property (!miso_oe_n_o);
endmodule
bind spi_irq_flags_data_port spi_port_checker spi_port_checker_inst
(
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.irq_o(irq_o), .irq_ack_i(irq_ack_i), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o),
	.mosi_oe_n_o(mosi_oe_n_o), .miso_oe_n_o(miso_oe_n_o), .ss_n_i(ss_n_i)
);

// [dv/tb.sv]
// Self-checking bench for the serial flag and data block
`timescale 1ns/1ps
module tb;
import spi_irq_pkg::*;
typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
logic clk_i = 1'h0;
logic rst_i = 1'h1;
logic cyc_i = 1'h0;
logic stb_i = 1'h0;
logic we_i = 1'h0;
logic irq_ack_i = 1'h0;
logic [7:0] adr_i = 8'h00;
logic [3:0] sel_i = 4'h1;
logic [31:0] dat_i = 32'h0;
logic [31:0] dat_o;
logic ack_o, irq_o, sck_o, sck_oe_n_o, mosi_o, mosi_oe_n_o, miso_o, miso_oe_n_o;
logic p_sck, p_mosi, p_miso, ss_n_i;
logic [7:0] rd;
int fail_count = 0;
int compares = 0;
wire sck_w = sck_oe_n_o ? p_sck : sck_o;
wire mosi_w = mosi_oe_n_o ? p_mosi : mosi_o;
wire miso_w = miso_oe_n_o ? p_miso : miso_o;
row_t rows [15] = '{'{1'h0, 8'h08, 8'h00, 8'h00}, '{1'h0, 8'h0C, 8'h00, 8'h00},
	'{1'h0, 8'h10, 8'h00, 8'h00}, '{1'h0, 8'h14, 8'h00, 8'h00}, '{1'h1, 8'h08, 8'hF1, 8'h00},
	'{1'h0, 8'h08, 8'h00, 8'h01}, '{1'h1, 8'h14, 8'h80, 8'h00}, '{1'h0, 8'h08, 8'h00, 8'hF1},
	'{1'h0, 8'h0C, 8'h00, 8'h00}, '{1'h1, 8'h14, 8'h00, 8'h00}, '{1'h1, 8'h20, 8'hFF, 8'h00},
	'{1'h0, 8'h20, 8'h00, 8'h00}, '{1'h0, 8'h14, 8'h00, 8'h00}, '{1'h1, 8'h08, 8'h00, 8'h00},
	'{1'h0, 8'h08, 8'h00, 8'h00}};
always #2.5 clk_i = ~clk_i;
spi_irq_flags_data_port spi_irq_flags_data_port_inst
(
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.irq_o(irq_o), .irq_ack_i(irq_ack_i), .sck_i(sck_w), .sck_o(sck_o),
	.sck_oe_n_o(sck_oe_n_o), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n_o),
	.miso_i(miso_w), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o), .ss_n_i(ss_n_i)
);
spi_far_end far
(
	.sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w), .sck_o(p_sck),
	.mosi_o(p_mosi), .miso_o(p_miso), .ss_n_o(ss_n_i)
);
////////////////////////////////////////
task chk(input logic [7:0] seen, input logic [7:0] exp);
	compares++;
	if (seen !== exp)
	begin
		fail_count++;
		$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
	end
endtask
// Holds the request until ack is sampled; no fixed latency assumed
task wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
	@(posedge clk_i);
	cyc_i <= 1'h1;
	stb_i <= 1'h1;
	we_i <= w;
	adr_i <= a;
	dat_i <= {24'h0, d};
	@(posedge clk_i);
	while (ack_o !== 1'h1)
		@(posedge clk_i);
	r = dat_o[7:0];
	cyc_i <= 1'h0;
	stb_i <= 1'h0;
endtask
task wait_irq;
	for (int n = 0; n < 2000 && irq_o !== 1'h1; n++)
		@(posedge clk_i);
	chk({7'h0, irq_o}, 8'h01);
endtask
task final_report;
	$display("compares %0d fail_count %0d", compares, fail_count);
	if (fail_count == 0 && compares > 0)
		$display("DONE - PASS");
	else
		$display("DONE - FAIL");
	$finish;
endtask
////////////////////////////////////////
initial
begin
	#200000;
	fail_count++;
	$display("watchdog expired");
	final_report;
end
initial
begin
	repeat (4) @(posedge clk_i);
	rst_i <= 1'h0;
	foreach (rows[i])
	begin
		wb(rows[i].w, rows[i].a, rows[i].d, rd);
		if (!rows[i].w)
			chk(rd, rows[i].e);
	end
	$display("register table done");
	// Byte lane 0 off: the enable write must be dropped
	@(posedge clk_i);
	sel_i <= 4'h0;
	wb(1'h1, 8'h08, 8'hF1, rd);
	sel_i <= 4'h1;
	wb(1'h0, 8'h08, 8'h00, rd);
	chk(rd, 8'h00);
	$display("lane select done");
	far.load(8'hA5);
	wb(1'h1, 8'h14, 8'h03, rd);
	wb(1'h1, 8'h08, 8'h01, rd);
	wb(1'h1, 8'h10, 8'h3C, rd);
	repeat (10) @(posedge clk_i);
	wb(1'h1, 8'h10, 8'h77, rd);
	wait_irq;
	chk(far.rx_q, 8'h3C);
	wb(1'h0, 8'h0C, 8'h00, rd);
	chk(rd, 8'hC0);
	wb(1'h0, 8'h10, 8'h00, rd);
	chk(rd, 8'hA5);
	wb(1'h0, 8'h0C, 8'h00, rd);
	chk(rd, 8'h00);
	chk({7'h0, irq_o}, 8'h00);
	wb(1'h1, 8'h10, 8'h81, rd);
	wait_irq;
	irq_ack_i <= 1'h1;
	@(posedge clk_i);
	irq_ack_i <= 1'h0;
	repeat (3) @(posedge clk_i);
	chk({7'h0, irq_o}, 8'h00);
	$display("normal host transfer done");
	wb(1'h1, 8'h14, 8'h03, rd);
	far.sel(1'h0);
	wait_irq;
	wb(1'h0, 8'h0C, 8'h00, rd);
	chk(rd, 8'h80);
	wb(1'h0, 8'h14, 8'h00, rd);
	chk(rd, 8'h01);
	far.sel(1'h1);
	wb(1'h0, 8'h10, 8'h00, rd);
	$display("select trigger normal done");
	wb(1'h1, 8'h14, 8'h81, rd);
	wb(1'h1, 8'h08, 8'h80, rd);
	wb(1'h1, 8'h10, 8'h5A, rd);
	far.send(8'h11);
	chk(far.got_q, 8'h5A);
	far.send(8'h22);
	far.send(8'h33);
	repeat (4) @(posedge clk_i);
	wb(1'h0, 8'h0C, 8'h00, rd);
	chk(rd, 8'hE0);
	chk({7'h0, irq_o}, 8'h01);
	far.send(8'h44);
	far.sel(1'h1);
	repeat (4) @(posedge clk_i);
	wb(1'h0, 8'h0C, 8'h00, rd);
	chk(rd, 8'hE1);
	wb(1'h0, 8'h10, 8'h00, rd);
	chk(rd, 8'h11);
	wb(1'h0, 8'h0C, 8'h00, rd);
	chk(rd, 8'hE0);
	wb(1'h1, 8'h0C, 8'hD1, rd);
	wb(1'h0, 8'h0C, 8'h00, rd);
	chk(rd, 8'h20);
	chk({7'h0, irq_o}, 8'h00);
	$display("buffered client done");
	wb(1'h1, 8'h14, 8'h87, rd);
	far.sel(1'h0);
	repeat (8) @(posedge clk_i);
	wb(1'h0, 8'h0C, 8'h00, rd);
	chk(rd & 8'h10, 8'h00);
	far.sel(1'h1);
	wb(1'h1, 8'h14, 8'h83, rd);
	far.sel(1'h0);
	repeat (8) @(posedge clk_i);
	wb(1'h0, 8'h0C, 8'h00, rd);
	chk(rd & 8'h10, 8'h10);
	far.sel(1'h1);
	$display("buffered select trigger done");
	final_report;
end
endmodule
